// ---- hdl/dascm_regs.vh ----
// Constants for the drive auto-setup and loop-mode master
//
// Function
// - Master writes mode -2 (0xfe), then enables operation, before auto setup.
// - Auto setup starts when controlword bit 4 is set in operation enabled.
// - Master must restart the drive after auto setup; homing is not enough.
// - Master selects velocity mode by writing mode value two.
// - Master writes target velocity; drive turns at it once enabled.
// - Writing six into the controlword stops the motor.
// - Master reads back objects after each transfer to confirm acceptance; the code reads back writes only, not the statusword polls.
// - Avoid cyclic synchronous position or velocity modes with open loop.
// - Submode bit 0 clear selects open loop, set selects closed loop.
// - Submode bit 3 set enables standstill current reduction.
// - Master configures pole pairs: 1.8 degrees is 50, 0.9 is 100.
// - Master writes maximum motor current in milliamperes.
`ifndef DASCM_REGS_VH
`define DASCM_REGS_VH
// Software register offsets
`define DASCM_A_CMD      8'h00
`define DASCM_A_STAT     8'h04
`define DASCM_A_TVEL     8'h08
`define DASCM_A_POLES    8'h0c
`define DASCM_A_IMAX     8'h10
`define DASCM_A_SUBM     8'h14
`define DASCM_A_IDLE     8'h18
`define DASCM_A_RED      8'h1c
`define DASCM_A_MODE     8'h20
`define DASCM_A_HOME     8'h24
`define DASCM_A_SW       8'h28
// Reset values of the configuration registers
`define DASCM_R_POLES    32'h00000032
`define DASCM_R_SUBM     32'h00000001
// Commands written to the command register
`define DASCM_C_AUTOSET  3'h1
`define DASCM_C_VELRUN   3'h2
`define DASCM_C_STOP     3'h3
`define DASCM_C_LOOPCFG  3'h4
`define DASCM_C_SETMODE  3'h5
`define DASCM_C_RESTART  3'h6
// Status bit positions
`define DASCM_S_BUSY     0
`define DASCM_S_ERR      1
`define DASCM_S_ASDONE   2
`define DASCM_S_INDEX    3
`define DASCM_S_RESTART  4
`define DASCM_S_OPEN     5
`define DASCM_S_REFUSED  6
// Submode register fields
`define DASCM_B_LOOP     0
`define DASCM_B_REDUCE   3
`define DASCM_B_BLDC     6
// Drive objects
`define DASCM_O_CW       16'h6040
`define DASCM_O_SW       16'h6041
`define DASCM_O_MODE     16'h6060
`define DASCM_O_TVEL     16'h6042
`define DASCM_O_HOME     16'h6098
`define DASCM_O_POLES    16'h2030
`define DASCM_O_IMAX     16'h2031
`define DASCM_O_SUBM     16'h3202
`define DASCM_O_IDLE     16'h2036
`define DASCM_O_RED      16'h2037
// Object values
`define DASCM_V_AUTOSET  32'h000000fe
`define DASCM_V_VEL      32'h00000002
`define DASCM_V_SHUTDN   32'h00000006
`define DASCM_V_SWON     32'h00000007
`define DASCM_V_ENOP     32'h0000000f
`define DASCM_V_ENOMS    32'h0000001f
`define DASCM_SW_ASDONE  12
`define DASCM_SW_INDEX   10
`define DASCM_CW_OMS     4
// Operating mode codes
`define DASCM_M_HOMING   8'h06
`define DASCM_M_PTORQUE  8'h04
`define DASCM_M_CSP      8'h08
`define DASCM_M_CSV      8'h09
`define DASCM_M_CST      8'h0a
// Step operations
`define DASCM_OP_END     2'h0
`define DASCM_OP_WR      2'h1
`define DASCM_OP_POLL    2'h2
`endif

// ---- hdl/dascm_obj_port.v ----
// Object access port: one read or write transfer to the drive
`timescale 1ns/100ps
module dascm_obj_port (
   clock,
   arst_n,
   go,
   go_wr,
   go_index,
   go_sub,
   go_wdata,
   done,
   rdata,
   dev_req,
   dev_we,
   dev_index,
   dev_sub,
   dev_wdata,
   dev_ack,
   dev_rdata
);
   input  wire        clock;
   input  wire        arst_n;
   input  wire        go;
   input  wire        go_wr;
   input  wire [15:0] go_index;
   input  wire [7:0]  go_sub;
   input  wire [31:0] go_wdata;
   output reg         done;
   output reg  [31:0] rdata;
   output reg         dev_req;
   output reg         dev_we;
   output reg  [15:0] dev_index;
   output reg  [7:0]  dev_sub;
   output reg  [31:0] dev_wdata;
   input  wire        dev_ack;
   input  wire [31:0] dev_rdata;

   // Request is held until the drive acknowledges; go is ignored meanwhile
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         done      <= 1'b0;
         rdata     <= 32'h00000000;
         dev_req   <= 1'b0;
         dev_we    <= 1'b0;
         dev_index <= 16'h0000;
         dev_sub   <= 8'h00;
         dev_wdata <= 32'h00000000;
      end else begin
         done <= 1'b0;
         if (dev_req) begin
            if (dev_ack) begin
               dev_req <= 1'b0;
               dev_we  <= 1'b0;
               rdata   <= dev_rdata;
               done    <= 1'b1;
            end
         end else if (go) begin
            dev_req   <= 1'b1;
            dev_we    <= go_wr;
            dev_index <= go_index;
            dev_sub   <= go_sub;
            dev_wdata <= go_wdata;
         end
      end
   end
endmodule // dascm_obj_port

// ---- hdl/dascm_ctrl.v ----
// Drive master: auto setup, test run, stop and loop-mode configuration
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "dascm_regs.vh"
module dascm_ctrl (
   clock,
   arst_n,
   sw_addr,
   sw_wdata,
   sw_we,
   sw_re,
   sw_rdata,
   dev_req,
   dev_we,
   dev_index,
   dev_sub,
   dev_wdata,
   dev_ack,
   dev_rdata
);
   input  wire        clock;
   input  wire        arst_n;
   input  wire [7:0]  sw_addr;
   input  wire [31:0] sw_wdata;
   input  wire        sw_we;
   input  wire        sw_re;
   output reg  [31:0] sw_rdata;
   output wire        dev_req;
   output wire        dev_we;
   output wire [15:0] dev_index;
   output wire [7:0]  dev_sub;
   output wire [31:0] dev_wdata;
   input  wire        dev_ack;
   input  wire [31:0] dev_rdata;

   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_ISSUE = 3'h1;
   localparam [2:0] S_WAIT  = 3'h2;
   localparam [2:0] S_RBW   = 3'h3;
   localparam [2:0] S_NEXT  = 3'h4;

   reg [2:0]  state_q;
   reg [2:0]  cmd_q;
   reg [2:0]  step_q;
   reg [31:0] tvel_q;
   reg [31:0] poles_q;
   reg [31:0] imax_q;
   reg [31:0] subm_q;
   reg [31:0] idle_q;
   reg [31:0] red_q;
   reg [7:0]  mode_q;
   reg [7:0]  home_q;
   reg [15:0] sw_q;
   reg        err_q;
   reg        refused_q;
   reg        as_done_q;
   reg        index_q;
   reg        restart_q;
   reg        open_q;
   reg        go;
   reg        go_wr;
   wire       pdone;
   wire [31:0] prdata;
   wire [57:0] cur;
   wire [1:0]  cur_op;
   wire [15:0] cur_idx;
   wire [7:0]  cur_sub;
   wire [31:0] cur_data;
   wire [2:0]  new_cmd;
   wire        cmd_wr;
   wire        refuse;
   wire        loop_cl;

   // Closed loop is forced for brushless motors whatever software asks
   assign loop_cl = subm_q[`DASCM_B_LOOP] | subm_q[`DASCM_B_BLDC];

   // Mode, homing and loop combination that the drive can honour
   function mode_ok;
      input [7:0] m;
      input       cl;
      input [7:0] hm;
      begin
         mode_ok = 1'b1;
         if (!cl) begin
            if (m == `DASCM_M_PTORQUE || m == `DASCM_M_CST)
               mode_ok = 1'b0;
            if (m == `DASCM_M_CSP || m == `DASCM_M_CSV)
               mode_ok = 1'b0;
            // Methods -4 to -1 home against a block and need feedback
            if (m == `DASCM_M_HOMING && hm[7] && hm >= 8'hfc)
               mode_ok = 1'b0;
         end
      end
   endfunction

   // Commands that change the operating mode of the drive
   function mode_cmd;
      input [2:0] c;
      begin
         mode_cmd = (c == `DASCM_C_AUTOSET) || (c == `DASCM_C_VELRUN) ||
                    (c == `DASCM_C_SETMODE);
      end
   endfunction

   // Step list: {op, object, subindex, value}
   function [57:0] step;
      input [2:0] c;
      input [2:0] s;
      reg   [1:0]  op;
      reg   [15:0] ix;
      reg   [31:0] v;
      begin
         op = `DASCM_OP_WR;
         ix = `DASCM_O_CW;
         v  = `DASCM_V_SHUTDN;
         case (c)
            `DASCM_C_AUTOSET: begin
               case (s)
                  3'h0: begin
                     ix = `DASCM_O_MODE;
                     v  = `DASCM_V_AUTOSET;
                  end
                  3'h1: v = `DASCM_V_SHUTDN;
                  3'h2: v = `DASCM_V_SWON;
                  3'h3: v = `DASCM_V_ENOP;
                  3'h4: v = `DASCM_V_ENOMS;
                  3'h5: begin
                     op = `DASCM_OP_POLL;
                     ix = `DASCM_O_SW;
                  end
                  default: op = `DASCM_OP_END;
               endcase
            end
            `DASCM_C_VELRUN: begin
               case (s)
                  3'h0: begin
                     ix = `DASCM_O_MODE;
                     v  = `DASCM_V_VEL;
                  end
                  3'h1: begin
                     ix = `DASCM_O_TVEL;
                     v  = tvel_q;
                  end
                  3'h2: v = `DASCM_V_SHUTDN;
                  3'h3: v = `DASCM_V_SWON;
                  3'h4: v = `DASCM_V_ENOP;
                  default: op = `DASCM_OP_END;
               endcase
            end
            `DASCM_C_STOP: begin
               if (s != 3'h0)
                  op = `DASCM_OP_END;
               v = `DASCM_V_SHUTDN;
            end
            `DASCM_C_LOOPCFG: begin
               case (s)
                  3'h0: begin
                     ix = `DASCM_O_POLES;
                     v  = poles_q;
                  end
                  3'h1: begin
                     ix = `DASCM_O_IMAX;
                     v  = imax_q;
                  end
                  3'h2: begin
                     ix = `DASCM_O_SUBM;
                     v  = {subm_q[31:1], loop_cl};
                  end
                  3'h3: begin
                     ix = `DASCM_O_IDLE;
                     v  = idle_q;
                  end
                  3'h4: begin
                     ix = `DASCM_O_RED;
                     v  = red_q;
                  end
                  default: op = `DASCM_OP_END;
               endcase
            end
            `DASCM_C_SETMODE: begin
               case (s)
                  3'h0: begin
                     ix = `DASCM_O_HOME;
                     v  = {{24{home_q[7]}}, home_q};
                  end
                  3'h1: begin
                     ix = `DASCM_O_MODE;
                     v  = {{24{mode_q[7]}}, mode_q};
                  end
                  default: op = `DASCM_OP_END;
               endcase
            end
            default: op = `DASCM_OP_END;
         endcase
         step = {op, ix, 8'h00, v};
      end
   endfunction

   assign cur      = step(cmd_q, step_q);
   assign cur_op   = cur[57:56];
   assign cur_idx  = cur[55:40];
   assign cur_sub  = cur[39:32];
   assign cur_data = cur[31:0];
   assign cmd_wr   = sw_we && (sw_addr == `DASCM_A_CMD);
   assign new_cmd  = sw_wdata[2:0];
   // Mode changes wait for a stop, and motion waits for a drive restart
   assign refuse = (state_q != S_IDLE) ||
                   (mode_cmd(new_cmd) && open_q) ||
                   (mode_cmd(new_cmd) && restart_q) ||
                   (new_cmd == `DASCM_C_SETMODE && !mode_ok(mode_q, loop_cl, home_q));

   // Software configuration registers
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tvel_q  <= 32'h00000000;
         poles_q <= `DASCM_R_POLES;
         imax_q  <= 32'h00000000;
         subm_q  <= `DASCM_R_SUBM;
         idle_q  <= 32'h00000000;
         red_q   <= 32'h00000000;
         mode_q  <= 8'h00;
         home_q  <= 8'h00;
      end else if (sw_we) begin
         case (sw_addr)
            `DASCM_A_TVEL:  tvel_q  <= sw_wdata;
            `DASCM_A_POLES: poles_q <= sw_wdata;
            `DASCM_A_IMAX:  imax_q  <= sw_wdata;
            `DASCM_A_SUBM:  subm_q  <= sw_wdata;
            `DASCM_A_IDLE:  idle_q  <= sw_wdata;
            `DASCM_A_RED:   red_q   <= sw_wdata;
            `DASCM_A_MODE:  mode_q  <= sw_wdata[7:0];
            `DASCM_A_HOME:  home_q  <= sw_wdata[7:0];
            default: ;
         endcase
      end
   end

   // Sequencer
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q   <= S_IDLE;
         cmd_q     <= 3'h0;
         step_q    <= 3'h0;
         sw_q      <= 16'h0000;
         err_q     <= 1'b0;
         refused_q <= 1'b0;
         as_done_q <= 1'b0;
         index_q   <= 1'b0;
         restart_q <= 1'b0;
         open_q    <= 1'b0;
         go        <= 1'b0;
         go_wr     <= 1'b0;
      end else begin
         go <= 1'b0;
         // Error flags clear on a write of one; a new error wins
         if (sw_we && sw_addr == `DASCM_A_STAT) begin
            if (sw_wdata[`DASCM_S_ERR])
               err_q <= 1'b0;
            if (sw_wdata[`DASCM_S_REFUSED])
               refused_q <= 1'b0;
         end
         if (cmd_wr) begin
            if (refuse) begin
               refused_q <= 1'b1;
            end else if (new_cmd == `DASCM_C_RESTART) begin
               restart_q <= 1'b0;
               open_q    <= 1'b0;
            end else begin
               cmd_q   <= new_cmd;
               step_q  <= 3'h0;
               state_q <= S_ISSUE;
               if (new_cmd == `DASCM_C_AUTOSET) begin
                  as_done_q <= 1'b0;
                  index_q   <= 1'b0;
               end
            end
         end
         case (state_q)
            S_IDLE: ;
            S_ISSUE: begin
               if (cur_op == `DASCM_OP_END) begin
                  state_q <= S_IDLE;
                  if (cmd_q == `DASCM_C_AUTOSET || cmd_q == `DASCM_C_VELRUN)
                     open_q <= 1'b1;
                  if (cmd_q == `DASCM_C_STOP)
                     open_q <= 1'b0;
               end else begin
                  go      <= 1'b1;
                  go_wr   <= (cur_op == `DASCM_OP_WR);
                  state_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (pdone) begin
                  if (cur_op == `DASCM_OP_POLL) begin
                     sw_q <= prdata[15:0];
                     if (prdata[`DASCM_SW_ASDONE]) begin
                        as_done_q <= 1'b1;
                        index_q   <= prdata[`DASCM_SW_INDEX];
                        restart_q <= 1'b1;
                        state_q   <= S_NEXT;
                     end else begin
                        go <= 1'b1;
                     end
                  end else begin
                     go      <= 1'b1;
                     go_wr   <= 1'b0;
                     state_q <= S_RBW;
                  end
               end
            end
            S_RBW: begin
               if (pdone) begin
                  if (prdata != cur_data) begin
                     err_q   <= 1'b1;
                     state_q <= S_IDLE;
                  end else begin
                     state_q <= S_NEXT;
                  end
               end
            end
            S_NEXT: begin
               step_q  <= step_q + 3'h1;
               state_q <= S_ISSUE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Read data stand one cycle after the strobe
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sw_rdata <= 32'h00000000;
      end else begin
         sw_rdata <= 32'h00000000;
         if (sw_re) begin
            case (sw_addr)
               `DASCM_A_CMD:   sw_rdata <= {29'h00000000, cmd_q};
               `DASCM_A_STAT:  sw_rdata <= {25'h0000000, refused_q, open_q, restart_q,
                                            index_q, as_done_q, err_q,
                                            state_q != S_IDLE};
               `DASCM_A_TVEL:  sw_rdata <= tvel_q;
               `DASCM_A_POLES: sw_rdata <= poles_q;
               `DASCM_A_IMAX:  sw_rdata <= imax_q;
               `DASCM_A_SUBM:  sw_rdata <= subm_q;
               `DASCM_A_IDLE:  sw_rdata <= idle_q;
               `DASCM_A_RED:   sw_rdata <= red_q;
               `DASCM_A_MODE:  sw_rdata <= {24'h000000, mode_q};
               `DASCM_A_HOME:  sw_rdata <= {24'h000000, home_q};
               `DASCM_A_SW:    sw_rdata <= {16'h0000, sw_q};
               default:        sw_rdata <= 32'h00000000;
            endcase
         end
      end
   end

   dascm_obj_port u_port (
      .clock     (clock),
      .arst_n    (arst_n),
      .go        (go),
      .go_wr     (go_wr),
      .go_index  (cur_idx),
      .go_sub    (cur_sub),
      .go_wdata  (cur_data),
      .done      (pdone),
      .rdata     (prdata),
      .dev_req   (dev_req),
      .dev_we    (dev_we),
      .dev_index (dev_index),
      .dev_sub   (dev_sub),
      .dev_wdata (dev_wdata),
      .dev_ack   (dev_ack),
      .dev_rdata (dev_rdata)
   );
endmodule // dascm_ctrl

// ---- verification/dascm_ctrl_properties.sv ----
// Port checker of the drive master, bound into its top module
`timescale 1ns/100ps
module dascm_ctrl_props (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic [7:0]  sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic        sw_we,
   input wire logic        sw_re,
   input wire logic [31:0] sw_rdata,
   input wire logic        dev_req,
   input wire logic        dev_we,
   input wire logic [15:0] dev_index,
   input wire logic [7:0]  dev_sub,
   input wire logic [31:0] dev_wdata,
   input wire logic        dev_ack,
   input wire logic [31:0] dev_rdata
);
   logic        en_q;
   logic [31:0] mode_q;
   logic [31:0] subm_q;
   wire         wr_go = dev_req && dev_we;
   // Track only acknowledged writes, as the drive does
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         en_q   <= 1'b0;
         mode_q <= 32'h0;
         subm_q <= 32'h1;
      end else if (wr_go && dev_ack) begin
         if (dev_index == 16'h6040) en_q <= dev_wdata[3:0] == 4'hf;
         if (dev_index == 16'h6060) mode_q <= dev_wdata;
         if (dev_index == 16'h3202) subm_q <= dev_wdata;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   req_hold_a: assert property (dev_req && !dev_ack |=> dev_req && $stable(dev_we)
      && $stable(dev_index) && $stable(dev_wdata)) else $error("request moved before ack");
   req_drop_a: assert property (dev_req && dev_ack |=> !dev_req)
      else $error("request not dropped after ack");
   write_readback_a: assert property (wr_go && dev_ack |-> ##3 dev_req && !dev_we
      && dev_index == $past(dev_index, 3)) else $error("write not read back");
   sub_zero_a: assert property (dev_req |-> dev_sub == 8'h00) else $error("subindex not zero");
   oms_start_a: assert property (wr_go && dev_index == 16'h6040 && dev_wdata[4]
      |-> mode_q[7:0] == 8'hfe && en_q) else $error("mode bit set outside auto setup");
   mode_idle_a: assert property (wr_go && dev_index == 16'h6060 |-> !en_q)
      else $error("mode written while enabled");
   open_torque_a: assert property (wr_go && dev_index == 16'h6060 && !subm_q[0]
      |-> !(dev_wdata[7:0] inside {8'h04, 8'h08, 8'h09, 8'h0a}))
      else $error("forbidden mode in open loop");
   bldc_closed_a: assert property (wr_go && dev_index == 16'h3202 && dev_wdata[6]
      |-> dev_wdata[0]) else $error("brushless motor set to open loop");
   cw_value_a: assert property (wr_go && dev_index == 16'h6040
      |-> dev_wdata inside {32'h6, 32'h7, 32'hf, 32'h1f}) else $error("odd controlword");
   vel_target_a: assert property (wr_go && dev_index == 16'h6042 |-> mode_q == 32'h2)
      else $error("target velocity outside velocity mode");
   rdata_idle_a: assert property (!$past(sw_re) |-> sw_rdata == 32'h0)
      else $error("read data outside read cycle");
endmodule // dascm_ctrl_props
bind dascm_ctrl dascm_ctrl_props i_props (.clock(clock), .arst_n(arst_n), .sw_addr(sw_addr),
   .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .dev_req(dev_req),
   .dev_we(dev_we), .dev_index(dev_index), .dev_sub(dev_sub), .dev_wdata(dev_wdata),
   .dev_ack(dev_ack), .dev_rdata(dev_rdata));

// ---- verification/dascm_drive_model.sv ----
// Behavioural drive answering object requests of the master
`timescale 1ns/100ps
module dascm_drive_model #(parameter int MS_CYC = 2) (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        dev_req,
   input  wire logic        dev_we,
   input  wire logic [15:0] dev_index,
   input  wire logic [7:0]  dev_sub,
   input  wire logic [31:0] dev_wdata,
   input  wire logic [3:0]  lat,
   input  wire logic        index_here,
   output logic             dev_ack,
   output logic [31:0]      dev_rdata
);
   logic [31:0] obj [0:65535];
   logic        en_q;
   logic [3:0]  wait_q;
   logic [2:0]  as_q;
   logic        done_q;
   logic        idx_q;
   logic [1:0]  store_q;
   logic [3:0]  rev_q;
   logic [15:0] idle_q;
   wire         open = !obj[16'h3202][0];
   wire  [31:0] sw = {19'h0, done_q, 1'b0, idx_q, 4'h0, 2'h2, en_q ? 4'h7 : 4'h3};
   wire  [31:0] speed = (en_q && obj[16'h6060][7:0] == 8'h02) ? obj[16'h6042] : 32'h0;
   // Full set current unless reduction is on in open loop and the idle time has run out at standstill
   wire  [31:0] cur = (open && obj[16'h3202][3] && {16'h0, idle_q} >= obj[16'h2036] * MS_CYC)
                      ? obj[16'h2037] : obj[16'h2031];
   wire         bad = (dev_index == 16'h6060 && (en_q
      || (open && (dev_wdata[7:0] == 8'h04 || dev_wdata[7:0] == 8'h0a))
      || (open && dev_wdata[7:0] == 8'h06 && obj[16'h6098] >= 32'hfffffffc)))
      || (dev_index == 16'h3202 && dev_wdata[6] && !dev_wdata[0]);
   initial foreach (obj[j]) obj[j] = 32'h0;
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         {dev_ack, en_q, wait_q, as_q, done_q, idx_q, store_q, rev_q, idle_q} <= '0;
         dev_rdata <= 32'h0;
      end else begin
         dev_ack   <= 1'b0;
         dev_rdata <= ~dev_rdata; // Idle bus never repeats the last answer
         idle_q    <= en_q ? 16'h0 : idle_q + {15'h0, idle_q != 16'hffff};
         if (dev_req && !dev_ack && wait_q < lat) begin
            wait_q <= wait_q + 4'h1;
         end else if (dev_req && !dev_ack) begin
            wait_q  <= 4'h0;
            dev_ack <= 1'b1;
            if (dev_we && !bad) obj[dev_index] <= dev_wdata;
            if (!dev_we) dev_rdata <= (dev_index == 16'h6041) ? sw : obj[dev_index];
            if (dev_we && dev_index == 16'h6040) begin
               en_q <= dev_wdata[3:0] == 4'hf;
               if (dev_wdata[4] && en_q && obj[16'h6060][7:0] == 8'hfe) begin
                  as_q    <= 3'h4;
                  done_q  <= 1'b0;
                  store_q <= 2'b00;
               end
            end
            if (!dev_we && dev_index == 16'h6041 && as_q != 3'h0) begin
               as_q  <= as_q - 3'h1;
               rev_q <= rev_q + 4'h1;
               if (as_q == 3'h1) begin
                  done_q  <= 1'b1;
                  idx_q   <= index_here;
                  store_q <= 2'b11;
               end
            end
         end
      end
   end
endmodule // dascm_drive_model

// ---- verification/test_drive_autosetup_and_loop_mode_control.sv ----
// Self-checking bench of the drive master against the drive model
`timescale 1ns/100ps
`include "dascm_regs.vh"
module test_drive_autosetup_and_loop_mode_control;
   logic        clock;
   logic        arst_n;
   logic [7:0]  sw_addr;
   logic [31:0] sw_wdata;
   logic        sw_we;
   logic        sw_re;
   wire  [31:0] sw_rdata;
   wire         dev_req;
   wire         dev_we;
   wire         dev_ack;
   wire  [15:0] dev_index;
   wire  [7:0]  dev_sub;
   wire  [31:0] dev_wdata;
   wire  [31:0] dev_rdata;
   logic [3:0]  lat;
   logic        index_here;
   logic [31:0] rd;
   logic [31:0] first;
   logic [31:0] v;
   logic [7:0]  modes [4] = '{`DASCM_M_PTORQUE, `DASCM_M_CSP, `DASCM_M_CSV, `DASCM_M_CST};
   integer      seed;
   integer      miscompares;
   integer      cmp_count;
   integer      i;
   integer      k;
   dascm_ctrl i_dut (.clock(clock), .arst_n(arst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .dev_req(dev_req), .dev_we(dev_we),
      .dev_index(dev_index), .dev_sub(dev_sub), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
      .dev_rdata(dev_rdata));
   dascm_drive_model i_drive (.clock(clock), .arst_n(arst_n), .dev_req(dev_req),
      .dev_we(dev_we), .dev_index(dev_index), .dev_sub(dev_sub), .dev_wdata(dev_wdata),
      .lat(lat), .index_here(index_here), .dev_ack(dev_ack), .dev_rdata(dev_rdata));
   always #25 clock = ~clock;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Submode as the drive must hold it: brushless forces closed loop
   function automatic logic [31:0] exp_subm(input logic [31:0] s);
      return s | {31'h0, s[6]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_we    <= 1'b1;
      @(posedge clock);
      sw_we <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      sw_addr <= a;
      sw_re   <= 1'b1;
      @(posedge clock);
      sw_re <= 1'b0;
      #1 d = sw_rdata;
   endtask
   // Issue a command, wait for busy to clear, then check and clear the refusal flag
   task automatic cmd(input logic [2:0] c, input logic refused);
      lat <= 4'($random(seed));
      wr(`DASCM_A_CMD, {29'h0, c});
      i  = 0;
      rd = 32'h1;
      while (rd[`DASCM_S_BUSY] !== 1'b0 && i < 2000) begin
         rd_reg(`DASCM_A_STAT, rd);
         if (i == 0) first = rd;
         i = i + 1;
      end
      if (i >= 2000) miscompares = miscompares + 1;
      check({31'h0, rd[`DASCM_S_REFUSED]}, {31'h0, refused});
      check({31'h0, rd[`DASCM_S_ERR]}, 32'h0);
      wr(`DASCM_A_STAT, 32'h40);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #(50 * 60000);
      miscompares = miscompares + 1;
      stop_test;
   end
   initial begin
      {seed, miscompares, cmp_count} = {32'd27, 32'd0, 32'd0};
      {clock, arst_n, sw_addr, sw_wdata, sw_we, sw_re, lat, index_here} = '0;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      rd_reg(`DASCM_A_POLES, rd);
      check(rd, 32'h32);
      rd_reg(`DASCM_A_SUBM, rd);
      check(rd, 32'h1);
      wr(8'h3c, $random(seed));
      rd_reg(8'h3c, rd);
      check(rd, 32'h0);
      // Stepper with reduction first, then brushless which must stay closed loop
      for (k = 0; k < 2; k = k + 1) begin
         v = $random(seed) & 32'hffff;
         wr(`DASCM_A_POLES, k ? 32'd100 : 32'd50);
         wr(`DASCM_A_IMAX, v);
         wr(`DASCM_A_SUBM, k ? 32'h40 : 32'h8);
         wr(`DASCM_A_IDLE, 32'h3);
         wr(`DASCM_A_RED, v >> 1);
         cmd(`DASCM_C_LOOPCFG, 1'b0);
         check(i_drive.obj[16'h3202], exp_subm(k ? 32'h40 : 32'h8));
         check(i_drive.cur, k ? v : v >> 1);
         check(i_drive.obj[16'h2030], k ? 32'd100 : 32'd50);
         check(i_drive.obj[16'h2031], v);
         check(i_drive.obj[16'h2037], v >> 1);
      end
      wr(`DASCM_A_SUBM, 32'h8);
      cmd(`DASCM_C_LOOPCFG, 1'b0);
      for (k = 0; k < 4; k = k + 1) begin
         wr(`DASCM_A_MODE, {24'h0, modes[k]});
         cmd(`DASCM_C_SETMODE, 1'b1);
      end
      wr(`DASCM_A_HOME, 32'hfe);
      wr(`DASCM_A_MODE, 32'h6);
      cmd(`DASCM_C_SETMODE, 1'b1);
      wr(`DASCM_A_HOME, 32'h1);
      cmd(`DASCM_C_SETMODE, 1'b0);
      check(i_drive.obj[16'h6060], 32'h6);
      for (k = 0; k < 2; k = k + 1) begin
         index_here <= !k[0];
         cmd(`DASCM_C_AUTOSET, 1'b0);
         if (k == 1) check({31'h0, first[`DASCM_S_ASDONE]}, 32'h0);
         check({28'h0, rd[5:2]}, {28'h0, 2'b11, !k[0], 1'b1});
         check({30'h0, i_drive.store_q}, 32'h3);
         check({31'h0, i_drive.rev_q != 4'h0}, 32'h1);
         cmd(`DASCM_C_AUTOSET, 1'b1);
         cmd(`DASCM_C_STOP, 1'b0);
         cmd(`DASCM_C_RESTART, 1'b0);
      end
      v = $random(seed) & 32'h7fff;
      wr(`DASCM_A_TVEL, v);
      cmd(`DASCM_C_VELRUN, 1'b0);
      check(i_drive.speed, v);
      wr(`DASCM_A_MODE, 32'h2);
      cmd(`DASCM_C_SETMODE, 1'b1);
      cmd(`DASCM_C_STOP, 1'b0);
      check(i_drive.speed, 32'h0);
      check(i_drive.obj[16'h6040], 32'h6);
      stop_test;
   end
endmodule // test_drive_autosetup_and_loop_mode_control
